// ==== include/pcaof_pkg.sv ====
// Package for the port C alternate-function override block.
// Assumes a 50 MHz system clock and an active-high asynchronous reset.
package pcaof_pkg;

  // ------------------------------------------------------------------
  // Pin positions and numbering
  // ------------------------------------------------------------------
  localparam int PCAOF_RESET_BIT = 6;
  localparam int PCAOF_SCL_BIT = 5;
  localparam int PCAOF_SDA_BIT = 4;
  localparam int PCAOF_ADC_CHANS = 6;
  localparam int PCAOF_PORTC_PCINT_BASE = 8;
  localparam int PCAOF_PD6_PCINT = 22;
  localparam int PCAOF_PD7_PCINT = 23;
  localparam int PCAOF_PD_COMPARATOR_POSITIVE_INPUT_BIT = 6;
  localparam int PCAOF_PD_COMPARATOR_NEGATIVE_INPUT_BIT = 7;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int PCAOF_CLK_PERIOD_PS = 20000;
  localparam int PCAOF_SPIKE_NS = 50;
  // Least time, rounded up to whole cycles.
  localparam int PCAOF_SPIKE_CYC =
    (PCAOF_SPIKE_NS * 1000 + PCAOF_CLK_PERIOD_PS - 1) / PCAOF_CLK_PERIOD_PS;
  localparam logic [7:0] PCAOF_RST_BYTE = 8'h00;

  // ------------------------------------------------------------------
  // Per-pin override bundle
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pullup_override_enable;
    logic [7:0] pullup_override_value;
    logic [7:0] direction_override_enable;
    logic [7:0] direction_override_value;
    logic [7:0] port_value_override_enable;
    logic [7:0] port_value_override_value;
    logic [7:0] input_enable_override_enable;
    logic [7:0] input_enable_override_value;
  } pcaof_ovr_t;

  localparam pcaof_ovr_t PCAOF_OVR_RST = '0;

endpackage

// ==== rtl/pcaof_spike_filter.sv ====
// Spike filter for one two-wire line: a level must hold for CYC clocks.
// Assumes the input is synchronous to ref_clk.
`timescale 1ns/1ps
module pcaof_spike_filter #(
  parameter int CYC = 3
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Line
  input wire logic raw_in,
  output logic filt_out
);
  import pcaof_pkg::*;

  logic [3:0] cnt_q, cnt_d;
  logic out_q, out_d;

  always_comb begin
    cnt_d = 4'h0;
    out_d = out_q;
    if (raw_in != out_q) begin
      if (cnt_q >= 4'(CYC - 1)) begin
        out_d = raw_in;
      end else begin
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      out_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign filt_out = out_q;
endmodule

// ==== rtl/pcaof_top.sv ====
// Port C alternate-function override logic, plus port D comparator pins.
// Assumes pad, fuse and peripheral signals are synchronous to ref_clk.
//
// Notes on behaviour
// - Fuse programmed: bit 6 is plain I/O.
// - Fuse unprogrammed: bit 6 is the reset input.
// - Reset-pin mode: direction, latch, input read zero.
// - Two-wire enabled: bit 5 is serial clock.
// - Two-wire enabled: bit 4 is serial data.
// - Two-wire pins: 50 ns filter, open drain.
// - Filter sits only on two-wire input path.
// - Port C pin n feeds pin-change source 8+n.
// - Port D bits 7,6 feed sources 23,22.
// - Bit 6 pull-up, direction overrides follow fuse.
// - Two-wire overrides: gated pull-up, drive-low, zero.
// - Bits 0-5 input override from pin-change or disable.
// - Bit 7 only input-enable override from source 15.
// - Bits 0-5 route to analog channels 0-5.
`timescale 1ns/1ps
module pcaof_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Configuration
  input wire logic reset_pin_disable_fuse,
  input wire logic two_wire_enable,
  input wire logic pin_change_group1_enable,
  input wire logic global_pullup_disable,
  input wire logic [7:0] pin_change_mask_c,
  input wire logic [5:0] analog_input_disable,
  // Ordinary port C state
  input wire logic [7:0] portc_latch,
  input wire logic [7:0] portc_direction,
  input wire logic [7:0] portc_pad_in,
  // Two-wire peripheral drive-low requests
  input wire logic scl_drive_low,
  input wire logic sda_drive_low,
  // Port D comparator pins
  input wire logic [1:0] portd_cmp_pad_in,
  // Override outputs toward pads
  output pcaof_pkg::pcaof_ovr_t portc_ovr,
  output logic [7:0] portc_open_drain,
  output logic [7:0] portc_slew_limit,
  // Register read-back
  output logic [7:0] portc_direction_rd,
  output logic [7:0] portc_latch_rd,
  output logic [7:0] portc_input_rd,
  // Peripheral side
  output logic reset_pin_level,
  output logic scl_filtered,
  output logic sda_filtered,
  output logic [5:0] pad_analog_path,
  output logic [23:8] pin_change_sources
);
  import pcaof_pkg::*;

  // ------------------------------------------------------------------
  // Spike filters on the two-wire input path
  // ------------------------------------------------------------------
  logic scl_filt, sda_filt;

  pcaof_spike_filter #(.CYC(PCAOF_SPIKE_CYC)) u_scl_filter (
    .ref_clk(ref_clk),
    .rst(rst),
    .raw_in(portc_pad_in[PCAOF_SCL_BIT]),
    .filt_out(scl_filt)
  );

  pcaof_spike_filter #(.CYC(PCAOF_SPIKE_CYC)) u_sda_filter (
    .ref_clk(ref_clk),
    .rst(rst),
    .raw_in(portc_pad_in[PCAOF_SDA_BIT]),
    .filt_out(sda_filt)
  );

  // ------------------------------------------------------------------
  // Override computation
  // ------------------------------------------------------------------
  pcaof_ovr_t ovr_d, ovr_q;
  logic [7:0] od_d, od_q;
  logic [7:0] slew_d, slew_q;
  logic [7:0] pc_term;
  logic reset_mode;

  always_comb begin
    ovr_d = PCAOF_OVR_RST;
    od_d = PCAOF_RST_BYTE;
    slew_d = PCAOF_RST_BYTE;
    pc_term = pin_change_mask_c & {8{pin_change_group1_enable}};
    reset_mode = ~reset_pin_disable_fuse;
    for (int i = 0; i < PCAOF_ADC_CHANS; i++) begin
      ovr_d.input_enable_override_enable[i] =
        pc_term[i] | analog_input_disable[i];
      ovr_d.input_enable_override_value[i] = pc_term[i];
    end
    ovr_d.input_enable_override_enable[7] = pc_term[7];
    ovr_d.input_enable_override_value[7] = 1'b1;
    ovr_d.pullup_override_enable[PCAOF_RESET_BIT] = reset_pin_disable_fuse;
    ovr_d.pullup_override_value[PCAOF_RESET_BIT] = 1'b1;
    ovr_d.direction_override_enable[PCAOF_RESET_BIT] = reset_pin_disable_fuse;
    ovr_d.direction_override_value[PCAOF_RESET_BIT] = 1'b0;
    ovr_d.input_enable_override_enable[PCAOF_RESET_BIT] =
      reset_pin_disable_fuse | pc_term[PCAOF_RESET_BIT];
    ovr_d.input_enable_override_value[PCAOF_RESET_BIT] =
      reset_pin_disable_fuse;
    if (two_wire_enable) begin
      ovr_d.pullup_override_enable[PCAOF_SCL_BIT] = 1'b1;
      ovr_d.pullup_override_value[PCAOF_SCL_BIT] =
        portc_latch[PCAOF_SCL_BIT] & ~global_pullup_disable;
      ovr_d.direction_override_enable[PCAOF_SCL_BIT] = 1'b1;
      ovr_d.direction_override_value[PCAOF_SCL_BIT] = scl_drive_low;
      ovr_d.port_value_override_enable[PCAOF_SCL_BIT] = 1'b1;
      ovr_d.port_value_override_value[PCAOF_SCL_BIT] = 1'b0;
      ovr_d.pullup_override_enable[PCAOF_SDA_BIT] = 1'b1;
      ovr_d.pullup_override_value[PCAOF_SDA_BIT] =
        portc_latch[PCAOF_SDA_BIT] & ~global_pullup_disable;
      ovr_d.direction_override_enable[PCAOF_SDA_BIT] = 1'b1;
      ovr_d.direction_override_value[PCAOF_SDA_BIT] = sda_drive_low;
      ovr_d.port_value_override_enable[PCAOF_SDA_BIT] = 1'b1;
      ovr_d.port_value_override_value[PCAOF_SDA_BIT] = 1'b0;
      od_d[PCAOF_SCL_BIT] = 1'b1;
      od_d[PCAOF_SDA_BIT] = 1'b1;
      slew_d[PCAOF_SCL_BIT] = 1'b1;
      slew_d[PCAOF_SDA_BIT] = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Read-back, peripheral routing and pin-change numbering
  // ------------------------------------------------------------------
  logic [7:0] dir_rd_d, lat_rd_d, in_rd_d;
  logic [7:0] dir_rd_q, lat_rd_q, in_rd_q;
  logic rst_lvl_d, rst_lvl_q;
  logic scl_d, scl_q, sda_d, sda_q;
  logic [5:0] ana_d, ana_q;
  logic [23:8] pcs_d, pcs_q;

  always_comb begin
    dir_rd_d = portc_direction;
    lat_rd_d = portc_latch;
    in_rd_d = portc_pad_in;
    rst_lvl_d = 1'b1;
    pcs_d = '0;
    if (reset_mode) begin
      rst_lvl_d = portc_pad_in[PCAOF_RESET_BIT];
      dir_rd_d[PCAOF_RESET_BIT] = 1'b0;
      lat_rd_d[PCAOF_RESET_BIT] = 1'b0;
      in_rd_d[PCAOF_RESET_BIT] = 1'b0;
    end
    scl_d = two_wire_enable ? scl_filt : 1'b1;
    sda_d = two_wire_enable ? sda_filt : 1'b1;
    ana_d = portc_pad_in[PCAOF_ADC_CHANS-1:0];
    for (int n = 0; n < 8; n++) begin
      pcs_d[PCAOF_PORTC_PCINT_BASE + n] = portc_pad_in[n];
    end
    // relies on pins left as inputs
    pcs_d[PCAOF_PD6_PCINT] = portd_cmp_pad_in[0];
    pcs_d[PCAOF_PD7_PCINT] = portd_cmp_pad_in[1];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ovr_q <= PCAOF_OVR_RST;
      od_q <= PCAOF_RST_BYTE;
      slew_q <= PCAOF_RST_BYTE;
      dir_rd_q <= PCAOF_RST_BYTE;
      lat_rd_q <= PCAOF_RST_BYTE;
      in_rd_q <= PCAOF_RST_BYTE;
      rst_lvl_q <= 1'b1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      ana_q <= '0;
      pcs_q <= '0;
    end else begin
      ovr_q <= ovr_d;
      od_q <= od_d;
      slew_q <= slew_d;
      dir_rd_q <= dir_rd_d;
      lat_rd_q <= lat_rd_d;
      in_rd_q <= in_rd_d;
      rst_lvl_q <= rst_lvl_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
      ana_q <= ana_d;
      pcs_q <= pcs_d;
    end
  end

  assign portc_ovr = ovr_q;
  assign portc_open_drain = od_q;
  assign portc_slew_limit = slew_q;
  assign portc_direction_rd = dir_rd_q;
  assign portc_latch_rd = lat_rd_q;
  assign portc_input_rd = in_rd_q;
  assign reset_pin_level = rst_lvl_q;
  assign scl_filtered = scl_q;
  assign sda_filtered = sda_q;
  assign pad_analog_path = ana_q;
  assign pin_change_sources = pcs_q;
endmodule

// ==== verif/pcaof_top_bench.sv ====
// Self-checking bench for the port C override block.
// Assumes a 50 MHz clock and outputs one edge behind inputs.
`timescale 1ns/1ps
module pcaof_top_bench;
  import pcaof_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reset_pin_disable_fuse = 1'b0;
  logic two_wire_enable = 1'b0;
  logic pin_change_group1_enable = 1'b0;
  logic global_pullup_disable = 1'b0;
  logic [7:0] pin_change_mask_c = 8'h00;
  logic [5:0] analog_input_disable = 6'h00;
  logic [7:0] portc_latch = 8'h00;
  logic [7:0] portc_direction = 8'h00;
  logic [7:0] pad_rnd = 8'h00;
  logic scl_drive_low = 1'b0;
  logic sda_drive_low = 1'b0;
  logic [1:0] portd_cmp_pad_in = 2'h0;
  logic [1:0] ext_low = 2'h0;
  logic [1:0] tw_line;
  logic [7:0] portc_pad_in;
  pcaof_ovr_t portc_ovr;
  pcaof_ovr_t e_ovr;
  logic [7:0] portc_open_drain, portc_slew_limit, portc_direction_rd;
  logic [7:0] portc_latch_rd, portc_input_rd;
  logic reset_pin_level, scl_filtered, sda_filtered;
  logic [5:0] pad_analog_path;
  logic [23:8] pin_change_sources;
  logic [15:0] lf = 16'h10e8;
  logic [63:0] e_oth;
  int failures = 0;
  int cmp_count = 0;
  int n;
  always #10 ref_clk = ~ref_clk;
  assign portc_pad_in = {pad_rnd[7:6], tw_line, pad_rnd[3:0]};
  pcaof_top uut (.*);
  pcaof_tw_bus bus (
    .dev_low(portc_ovr.direction_override_enable[5:4]
      & portc_ovr.direction_override_value[5:4]),
    .ext_low(ext_low),
    .line(tw_line)
  );
  function automatic logic [15:0] lfsr(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(logic [63:0] got, logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Works out expected outputs from the inputs just before an edge.
  task automatic predict();
    logic [7:0] pc;
    logic [7:0] k;
    logic [1:0] tw;
    pc = pin_change_mask_c & {8{pin_change_group1_enable}};
    k = {1'b1, reset_pin_disable_fuse, 6'h3f};
    tw = {2{two_wire_enable}};
    e_ovr = '0;
    e_ovr.pullup_override_enable = {1'b0, reset_pin_disable_fuse, tw, 4'h0};
    e_ovr.pullup_override_value = {2'h1,
      tw & portc_latch[5:4] & ~{2{global_pullup_disable}}, 4'h0};
    e_ovr.direction_override_enable = e_ovr.pullup_override_enable;
    e_ovr.direction_override_value = {2'h0,
      tw & {scl_drive_low, sda_drive_low}, 4'h0};
    e_ovr.port_value_override_enable = {2'h0, tw, 4'h0};
    e_ovr.input_enable_override_enable = {pc[7],
      reset_pin_disable_fuse | pc[6], pc[5:0] | analog_input_disable};
    e_ovr.input_enable_override_value = {1'b1, reset_pin_disable_fuse, pc[5:0]};
    e_oth = {1'b0, {2'h0, tw, 4'h0}, {2'h0, tw, 4'h0}, portc_direction & k,
      portc_latch & k, portc_pad_in & k,
      reset_pin_disable_fuse | portc_pad_in[6], portc_pad_in[5:0],
      portd_cmp_pad_in, 6'h00, portc_pad_in};
  endtask
  task automatic cycle();
    logic t;
    @(negedge ref_clk);
    predict();
    t = two_wire_enable;
    @(posedge ref_clk);
    #1;
    chk(portc_ovr, e_ovr);
    chk({1'b0, portc_open_drain, portc_slew_limit, portc_direction_rd,
      portc_latch_rd, portc_input_rd, reset_pin_level, pad_analog_path,
      pin_change_sources}, e_oth);
    if (!t) chk({62'h0, scl_filtered, sda_filtered}, 64'h3);
  endtask
  task automatic rnd();
    logic [63:0] r;
    repeat (4) begin
      lf = lfsr(lf);
      r = {r[47:0], lf};
    end
    {reset_pin_disable_fuse, two_wire_enable, pin_change_group1_enable,
      global_pullup_disable, pin_change_mask_c, analog_input_disable,
      portc_latch, portc_direction, pad_rnd, scl_drive_low, sda_drive_low,
      portd_cmp_pad_in, ext_low} = r[47:0];
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    #1;
    chk(portc_ovr, 64'h0);
    rst = 1'b0;
    repeat (400) begin
      rnd();
      cycle();
    end
    $display("test random done");
    for (n = 0; n < 2; n++) begin
      {reset_pin_disable_fuse, portc_latch, portc_direction} = {n[0], 16'hffff};
      pad_rnd = 8'hff;
      cycle();
    end
    $display("test bit 6 corners done");
    {two_wire_enable, scl_drive_low, sda_drive_low, ext_low} = 5'h10;
    repeat (10) cycle();
    ext_low = 2'h3;
    repeat (2) cycle();
    ext_low = 2'h0;
    repeat (8) begin
      cycle();
      chk({62'h0, scl_filtered, sda_filtered}, 64'h3);
    end
    ext_low = 2'h3;
    for (n = 1; n <= 10 && {scl_filtered, sda_filtered} !== 2'h0; n++)
      cycle();
    chk(64'(n), 64'd5);
    $display("test spike filter done");
    // Mid-run reset: every output must fall back to its idle value.
    rst = 1'b1;
    @(posedge ref_clk);
    #1;
    chk(portc_ovr, 64'h0);
    chk({15'h0, portc_open_drain, portc_slew_limit, portc_direction_rd,
      portc_latch_rd, portc_input_rd, reset_pin_level, scl_filtered,
      sda_filtered, pad_analog_path}, 64'h1c0);
    chk({48'h0, pin_change_sources}, 64'h0);
    rst = 1'b0;
    repeat (4) begin
      rnd();
      cycle();
    end
    $display("test mid-run reset done");
    conclude();
  end
endmodule

// ==== verif/pcaof_top_sva.sv ====
// Checker for the port C override block, bound to its top module.
// Assumes every checked output lags its inputs by one ref_clk edge.
`timescale 1ns/1ps
module pcaof_top_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Inputs
  input wire logic reset_pin_disable_fuse,
  input wire logic two_wire_enable,
  input wire logic pin_change_group1_enable,
  input wire logic [7:0] pin_change_mask_c,
  input wire logic [5:0] analog_input_disable,
  input wire logic [7:0] portc_pad_in,
  input wire logic scl_drive_low,
  input wire logic sda_drive_low,
  // Outputs
  input wire pcaof_pkg::pcaof_ovr_t portc_ovr,
  input wire logic [7:0] portc_open_drain,
  input wire logic [7:0] portc_input_rd,
  input wire logic reset_pin_level
);
  import pcaof_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  property p_rd6;
    !reset_pin_disable_fuse |=> !portc_input_rd[6];
  endproperty
  a_rd6: assert property (p_rd6) else $error("bit 6 read not 0");
  property p_rpin;
    1 |=> reset_pin_level ==
      ($past(reset_pin_disable_fuse) | $past(portc_pad_in[6]));
  endproperty
  a_rpin: assert property (p_rpin) else $error("reset pin level");
  property p_od;
    1 |=> portc_open_drain == {2'h0, {2{$past(two_wire_enable)}}, 4'h0};
  endproperty
  a_od: assert property (p_od) else $error("open drain bits");
  property p_tw;
    two_wire_enable |=> portc_ovr.port_value_override_enable[5:4] == 2'h3
      && portc_ovr.direction_override_value[5] == $past(scl_drive_low)
      && portc_ovr.direction_override_value[4] == $past(sda_drive_low);
  endproperty
  a_tw: assert property (p_tw) else $error("two-wire takeover");
  property p_off;
    !two_wire_enable |=> portc_ovr.pullup_override_enable[5:4] == 2'h0
      && portc_ovr.port_value_override_enable[5:4] == 2'h0;
  endproperty
  a_off: assert property (p_off) else $error("two-wire left over");
  property p_ie;
    1 |=> portc_ovr.input_enable_override_enable[5:0] ==
      (($past(pin_change_mask_c[5:0]) & {6{$past(pin_change_group1_enable)}})
      | $past(analog_input_disable));
  endproperty
  a_ie: assert property (p_ie) else $error("input enable 5..0");
  property p_b6;
    1 |=> portc_ovr.direction_override_enable[6] ==
      $past(reset_pin_disable_fuse) && portc_ovr.pullup_override_value[6];
  endproperty
  a_b6: assert property (p_b6) else $error("bit 6 overrides");
  property p_b7;
    1 |=> portc_ovr.input_enable_override_enable[7] ==
      ($past(pin_change_mask_c[7]) & $past(pin_change_group1_enable));
  endproperty
  a_b7: assert property (p_b7) else $error("bit 7 input enable");
endmodule
bind pcaof_top pcaof_top_sva chk (.*);

// ==== verif/pcaof_tw_bus.sv ====
// Two-wire bus lines on port C bits 5 and 4, each with a pull-up.
// Assumes drivers only ever pull a line low.
`timescale 1ns/1ps
module pcaof_tw_bus (
  // Drivers pulling low
  input wire logic [1:0] dev_low,
  input wire logic [1:0] ext_low,
  // Line level
  output logic [1:0] line
);
  assign line = ~(dev_low | ext_low);
endmodule
